// >>> design/coef_store.sv
// volatile coefficient store with a write port and a two-slot zero fill
`timescale 1ns/1ns
`include "fir_dl_cfg.svh"
module coef_store #(
   parameter int DEPTH = `FD_MAX_COEF,
   parameter int WIDTH = `FD_COEF_W
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             wr_en,
   input  wire logic [5:0]       wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             clr_en,
   input  wire logic [5:0]       clr_addr,
   input  wire logic [5:0]       rd_addr,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   // flops, not ram macros, so that reset really clears the contents
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            if (wr_en && wr_addr == 6'(i)) begin
               mem_q[i] <= wr_data;
            end else if (clr_en && (clr_addr == 6'(i) ||
                         clr_addr + 6'd1 == 6'(i))) begin
               mem_q[i] <= '0;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_data <= '0;
      end else if (int'(rd_addr) < DEPTH) begin
         rd_data <= mem_q[rd_addr];
      end else begin
         rd_data <= '0;
      end
   end
endmodule

// >>> design/fir_dl_device.sv
// converter end: control write decode and user coefficient download
// Overview of operation
// - word: broadcast, address, zero, sign, magnitude
// - coefficients are 27-bit sign and magnitude
// - addressed words accepted only on strap match
// - broadcast with zero address reaches every device
// - checksum is 16-bit sum of all bytes
// - checksum word: address bits, zeros, sum
// - host sends checksum right after last coefficient
// - matching checksum sets download ok status bit
// - host starts with control write, enable set
// - coefficients go from symmetry point outward
// - length code: default or 6 to 48
// - unused slots zeroed, half period each
// - coefficients are lost on reset
// - host checks download ok via status
// - status-read control write returns status next
// - while enabled, writes are coefficient data
// - enable, read-select and sync bits self-clear
// - register write is address then 16 bits
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "fir_dl_cfg.svh"
module fir_dl_device import fir_dl_pkg::*; #(
   parameter logic [1:0] PART_CODE = 2'b01, // arbitrary value
   parameter logic [2:0] DIE_CODE  = 3'b001 // arbitrary value
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   fir_dl_link.device       link,
   input  wire logic [2:0]  strap_address_pin,
   input  wire logic [5:0]  coef_rd_addr,
   output logic      [26:0] coef_rd_data,
   output logic             user_filter_active,
   output logic             download_ok_flag,
   output logic             sync_pulse,
   output logic      [3:0]  filter_length_code,
   output logic      [2:0]  decimation_code,
   output logic             filter3_enable
);
   ////////////////////////////////////////////////////////////////////////
   // strap pins come from outside: two flops before use
   logic [2:0] strap_s1_q;
   logic [2:0] strap_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_s1_q <= 3'h0;
         strap_q    <= 3'h0;
      end else begin
         strap_s1_q <= strap_address_pin;
         strap_q    <= strap_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // word decode
   logic        wv;
   logic [31:0] wd;
   logic        addr_hit;
   logic        ctrl1_wr;
   logic [15:0] c1;

   assign wv = link.word_valid;
   assign wd = link.word_data;
   assign c1 = wd[15:0];
   // broadcast only counts with a zero address field
   assign addr_hit = wd[`FD_W_ALL]
      ? (wd[`FD_W_ADR_HI:`FD_W_ADR_LO] == 3'h0)
      : (wd[`FD_W_ADR_HI:`FD_W_ADR_LO] == strap_q);
   assign ctrl1_wr = wv &&
      wd[`FD_W_REG_HI:`FD_W_REG_LO] == `FD_REG_ADDR_CTRL1;

   ////////////////////////////////////////////////////////////////////////
   // download sequencing
   dl_state_type state_q;
   logic [5:0]   need_q;
   logic [5:0]   idx_q;
   logic [15:0]  sum_q;
   logic [5:0]   fill_q;
   logic         ram_wr;
   logic         csum_in;
   logic         start_dl;

   assign start_dl = state_q == DL_IDLE && ctrl1_wr && c1[`FD_C1_DL];
   // while loading, addressed writes are coefficient data until idx_q reaches need_q; the next is the checksum
   assign ram_wr  = state_q == DL_LOAD && wv && addr_hit &&
                    idx_q < need_q;
   assign csum_in = state_q == DL_LOAD && wv && addr_hit &&
                    idx_q >= need_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= DL_IDLE;
         need_q  <= 6'h00;
         idx_q   <= 6'h00;
         fill_q  <= 6'h00;
      end else begin
         case (state_q)
            DL_IDLE: begin
               if (start_dl) begin
                  state_q <= DL_LOAD;
                  need_q  <= coef_count_f(
                     c1[`FD_C1_FLEN_HI:`FD_C1_FLEN_LO]);
                  idx_q   <= 6'h00;
               end
            end
            DL_LOAD: begin
               if (ram_wr) begin
                  idx_q <= idx_q + 6'd1;
               end else if (csum_in) begin
                  state_q <= DL_FILL;
                  fill_q  <= idx_q;
               end
            end
            DL_FILL: begin
               // two slots per clock: each slot costs half a period
               if (int'(fill_q) + 2 >= `FD_MAX_COEF) begin
                  state_q <= DL_IDLE;
               end
               fill_q <= fill_q + 6'd2;
            end
            default: begin
               state_q <= DL_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checksum and result flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sum_q            <= 16'h0000;
         download_ok_flag <= 1'b0;
      end else if (start_dl) begin
         sum_q            <= 16'h0000;
         download_ok_flag <= 1'b0;
      end else if (ram_wr) begin
         sum_q <= sum_q + byte_sum_f(wd);
      end else if (csum_in) begin
         download_ok_flag <= sum_q == wd[`FD_W_CSUM_HI:0] &&
            wd[`FD_W_ZERO:16] == 12'h000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         user_filter_active <= 1'b0;
      end else if (start_dl) begin
         user_filter_active <= 1'b0;
      end else if (state_q == DL_FILL &&
                   int'(fill_q) + 2 >= `FD_MAX_COEF) begin
         user_filter_active <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // first control register fields
   localparam logic [15:0] CTRL1_RST = `FD_CTRL1_RESET;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filter_length_code <= CTRL1_RST[`FD_C1_FLEN_HI:`FD_C1_FLEN_LO];
         decimation_code    <= CTRL1_RST[`FD_C1_DEC_HI:0];
         filter3_enable     <= CTRL1_RST[`FD_C1_BYP];
      end else if (ctrl1_wr && state_q == DL_IDLE) begin
         filter_length_code <= c1[`FD_C1_FLEN_HI:`FD_C1_FLEN_LO];
         decimation_code    <= c1[`FD_C1_DEC_HI:0];
         filter3_enable     <= c1[`FD_C1_BYP];
      end
   end

   // sync is a single-cycle pulse, never stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_pulse <= 1'b0;
      end else begin
         sync_pulse <= ctrl1_wr && state_q == DL_IDLE &&
                       c1[`FD_C1_SYNC];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read selection, consumed by the next read
   read_sel_type sel_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_q <= SEL_DATA;
      end else if (ctrl1_wr && state_q == DL_IDLE &&
                   c1[`FD_C1_RD_OVR:`FD_C1_RD_STAT] != 4'h0) begin
         // only one may be set; the highest bit wins if not
         if (c1[`FD_C1_RD_OVR]) begin
            sel_q <= SEL_OVR;
         end else if (c1[`FD_C1_RD_GAIN]) begin
            sel_q <= SEL_GAIN;
         end else if (c1[`FD_C1_RD_OFF]) begin
            sel_q <= SEL_OFF;
         end else begin
            sel_q <= SEL_STAT;
         end
      end else if (link.read_req) begin
         sel_q <= SEL_DATA;
      end
   end

   logic [15:0] status_word;

   assign status_word = {PART_CODE, DIE_CODE, 1'b0, 1'b0, 1'b0,
                         download_ok_flag, 1'b1, user_filter_active,
                         filter3_enable, 1'b1, decimation_code};

   // conversion path is not modelled: a data read carries the low
   // status byte so the download flag is visible while reading data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.read_valid <= 1'b0;
         link.read_word  <= 16'h0000;
      end else begin
         link.read_valid <= link.read_req;
         if (link.read_req) begin
            case (sel_q)
               SEL_STAT: link.read_word <= status_word;
               SEL_DATA: link.read_word <= {8'h00, status_word[7:0]};
               default:  link.read_word <= 16'h0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // coefficient store
   coef_store #(
      .DEPTH (`FD_MAX_COEF),
      .WIDTH (`FD_COEF_W)
   ) i_coef_store (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .wr_en    (ram_wr),
      .wr_addr  (idx_q),
      .wr_data  (wd[`FD_W_SIGN:0]),
      .clr_en   (state_q == DL_FILL),
      .clr_addr (fill_q),
      .rd_addr  (coef_rd_addr),
      .rd_data  (coef_rd_data)
   );
endmodule

// >>> design/fir_dl_host.sv
// host controller end: ahb-lite registers driving the download link
`timescale 1ns/1ns
`include "fir_dl_cfg.svh"
module fir_dl_host import fir_dl_pkg::*; (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   fir_dl_link.host         link
);
   ////////////////////////////////////////////////////////////////////////
   // bus slave: one wait state, longer for link writes while the fill wait runs
   logic       pend_q;
   logic [7:0] a_q;
   logic       w_q;
   logic [7:0] wait_q;
   logic       is_send;
   logic       blocked;
   logic       do_it;
   logic       accept;

   assign accept  = hsel && htrans[1] && hready;
   assign is_send = a_q == `FD_H_CTRL || a_q == `FD_H_WORD;
   assign blocked = w_q && is_send && wait_q != 8'h00;
   assign do_it   = pend_q && !blocked;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_q    <= 1'b0;
         a_q       <= 8'h00;
         w_q       <= 1'b0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (accept) begin
         pend_q    <= 1'b1;
         a_q       <= haddr[7:0];
         w_q       <= hwrite;
         hreadyout <= 1'b0;
      end else if (do_it) begin
         pend_q    <= 1'b0;
         hreadyout <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // words onto the link
   logic        dl_q;
   logic [5:0]  need_q;
   logic [5:0]  sent_q;
   logic [15:0] sum_q;
   logic [3:0]  tgt_q;
   logic        rd_done_q;
   logic [15:0] rd_data_q;
   logic        snd;
   logic [31:0] fill_ns;

   assign snd = do_it && w_q && is_send;
   assign fill_ns = 32'(`FD_MAX_COEF - int'(need_q)) * `FD_FILL_SLOT_NS
                  + `FD_CLK_PERIOD_NS - 1;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.word_valid <= 1'b0;
         link.word_data  <= 32'h0000_0000;
      end else begin
         link.word_valid <= snd;
         if (snd) begin
            link.word_data <= (a_q == `FD_H_CTRL)
               ? {`FD_REG_ADDR_CTRL1, hwdata[15:0]}
               : hwdata;
         end
      end
   end

   // tracks the download so the checksum follows the last coefficient
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dl_q   <= 1'b0;
         need_q <= 6'h00;
         sent_q <= 6'h00;
         sum_q  <= 16'h0000;
         wait_q <= 8'h00;
         tgt_q  <= 4'h0;
      end else begin
         if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'd1;
         end
         if (snd && a_q == `FD_H_CTRL && hwdata[`FD_C1_DL]) begin
            dl_q   <= 1'b1;
            need_q <= coef_count_f(
               hwdata[`FD_C1_FLEN_HI:`FD_C1_FLEN_LO]);
            sent_q <= 6'h00;
            sum_q  <= 16'h0000;
         end else if (snd && a_q == `FD_H_WORD && dl_q &&
                      (sent_q == 6'h00 ||
                       hwdata[`FD_W_ALL:`FD_W_ADR_LO] == tgt_q)) begin
            // words for other addresses share the line, not the count
            tgt_q <= hwdata[`FD_W_ALL:`FD_W_ADR_LO];
            if (sent_q < need_q) begin
               sent_q <= sent_q + 6'd1;
               sum_q  <= sum_q + byte_sum_f(hwdata);
            end else begin
               dl_q   <= 1'b0;
               // one extra cycle covers the link register delay
               wait_q <= 8'(fill_ns / `FD_CLK_PERIOD_NS) + 8'd1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reads of the converter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.read_req <= 1'b0;
      end else begin
         link.read_req <= do_it && w_q && a_q == `FD_H_RDREQ;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_done_q <= 1'b0;
         rd_data_q <= 16'h0000;
      end else if (link.read_valid) begin
         rd_done_q <= 1'b1;
         rd_data_q <= link.read_word;
      end else if (link.read_req) begin
         rd_done_q <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (do_it && !w_q) begin
         case (a_q)
            `FD_H_STAT:  hrdata <= {24'h0000_00, rd_data_q[`FD_ST_DOWNLOAD_OK_FLAG],
                                    3'b000, rd_done_q, dl_q,
                                    wait_q != 8'h00, 1'b0};
            `FD_H_RDATA: hrdata <= {16'h0000, rd_data_q};
            `FD_H_SUM:   hrdata <= {16'h0000, sum_q};
            default:     hrdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// >>> include/fir_dl_cfg.svh
// constants for the coefficient download link: offsets, fields, timing
`ifndef FIR_DL_CFG_SVH
`define FIR_DL_CFG_SVH

// word layout on the serial data input
`define FD_W_ALL        31
`define FD_W_ADR_HI     30
`define FD_W_ADR_LO     28
`define FD_W_ZERO       27
`define FD_W_SIGN       26
`define FD_W_CSUM_HI    15
`define FD_W_REG_HI     31
`define FD_W_REG_LO     16

// register write word: address in the top half, data in the bottom
`define FD_REG_ADDR_CTRL1 16'h0001
`define FD_CTRL1_RESET    16'h001A

// first control register bits
`define FD_C1_DL        15
`define FD_C1_RD_OVR    14
`define FD_C1_RD_GAIN   13
`define FD_C1_RD_OFF    12
`define FD_C1_RD_STAT   11
`define FD_C1_SYNC      9
`define FD_C1_FLEN_HI   8
`define FD_C1_FLEN_LO   5
`define FD_C1_BYP       4
`define FD_C1_DEC_HI    2

// status word bits
`define FD_ST_DOWNLOAD_OK_FLAG     7
`define FD_ST_FILT_OK   6
`define FD_ST_UFILT     5

// coefficient store
`define FD_MAX_COEF     48
`define FD_COEF_STEP    6
`define FD_COEF_W       27

// timing: one zero-filled slot takes half an input clock period
`define FD_CLK_PERIOD_NS 100
`define FD_FILL_SLOT_NS  50

// host register offsets on the bus
`define FD_H_CTRL       8'h00
`define FD_H_WORD       8'h04
`define FD_H_RDREQ      8'h08
`define FD_H_STAT       8'h0C
`define FD_H_RDATA      8'h10
`define FD_H_SUM        8'h14

`endif

// >>> include/fir_dl_link.sv
// serial data input link between host controller and converter
`timescale 1ns/1ns
interface fir_dl_link;
   logic        word_valid;
   logic [31:0] word_data;
   logic        read_req;
   logic        read_valid;
   logic [15:0] read_word;

   modport device (
      input  word_valid,
      input  word_data,
      input  read_req,
      output read_valid,
      output read_word
   );

   modport host (
      output word_valid,
      output word_data,
      output read_req,
      input  read_valid,
      input  read_word
   );
endinterface

// >>> include/fir_dl_pkg.sv
// types and shared decoders for the coefficient download link
`include "fir_dl_cfg.svh"
package fir_dl_pkg;

   typedef enum logic [1:0] {
      DL_IDLE = 2'b00,
      DL_LOAD = 2'b01,
      DL_FILL = 2'b10
   } dl_state_type;

   typedef enum logic [2:0] {
      SEL_DATA = 3'b000,
      SEL_STAT = 3'b001,
      SEL_OVR  = 3'b010,
      SEL_GAIN = 3'b011,
      SEL_OFF  = 3'b100
   } read_sel_type;

   // number of coefficients for a filter length code; 0 for default
   function automatic logic [5:0] coef_count_f(input logic [3:0] flen);
      logic [5:0] half;
      half = {3'b000, flen[3:1]} + 6'd1;
      coef_count_f = flen[0] ? 6'(half * 6'(`FD_COEF_STEP)) : 6'd0;
   endfunction

   // sum of the four bytes of one word
   function automatic logic [15:0] byte_sum_f(input logic [31:0] w);
      byte_sum_f = {8'h00, w[31:24]} + {8'h00, w[23:16]}
                 + {8'h00, w[15:8]} + {8'h00, w[7:0]};
   endfunction

endpackage

// >>> verification/fir_coefficient_download_tb.sv
// testbench: ahb-lite host end driving the device end over the link
`timescale 1ns/1ns
module fir_coefficient_download_tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [2:0]  strap = 3'b000;
   logic [5:0]  cidx = 6'h00;
   logic [26:0] cdat;
   logic        ufa, dok, syncp, f3;
   logic [3:0]  flen;
   logic [2:0]  dec;
   int          error_cnt = 0;
   int          total_checks = 0;
   int          syncs = 0;
   logic [31:0] tbl [12] = '{32'h032B_9688, 32'h01BF_183C, 32'h0015_6626,
      32'h04A8_1E6A, 32'h045F_2A96, 32'h002C_49C2, 32'h0050_E9F6,
      32'h0010_DBD8, 32'h042F_DE54, 32'h0437_445A, 32'h041B_7D6E,
      32'h0404_3B5F};
   fir_dl_link link ();
   fir_dl_host i_fir_dl_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .link(link));
   fir_dl_device i_fir_dl_device (.hclk(hclk), .hresetn(hresetn),
      .link(link), .strap_address_pin(strap), .coef_rd_addr(cidx),
      .coef_rd_data(cdat), .user_filter_active(ufa),
      .download_ok_flag(dok), .sync_pulse(syncp),
      .filter_length_code(flen), .decimation_code(dec),
      .filter3_enable(f3));
   fir_dl_asserts i_fir_dl_asserts (.hclk(hclk), .hresetn(hresetn),
      .word_valid(link.word_valid), .word_data(link.word_data),
      .read_req(link.read_req), .read_valid(link.read_valid),
      .read_word(link.read_word));
   initial forever #50 hclk = ~hclk;
   always @(posedge hclk) if (syncp === 1'b1) syncs++;
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // values read right after an edge are those sampled at that edge
   task automatic hwait();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 200);
      if (n >= 200) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      htrans <= 2'b10;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      hwait();
      htrans <= 2'b00;
      hwdata <= d;
      hwait();
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic coef(input int i, input logic [26:0] e);
      cidx <= 6'(i);
      repeat (3) @(posedge hclk);
      chk(32'(cdat), 32'(e));
   endtask
   function automatic logic [15:0] bsum(input logic [31:0] w);
      return 16'(w[31:24]) + 16'(w[23:16]) + 16'(w[15:8]) + 16'(w[7:0]);
   endfunction
   // n words to one address, a foreign word fw mixed in, checksum + skew
   task automatic dl(input logic [3:0] aa, input int n,
                     input logic [31:0] fw, input logic [15:0] skew);
      logic [31:0] w;
      logic [31:0] r;
      logic [15:0] s;
      int c;
      int f;
      s = 16'h0000;
      wr(8'h00, 32'h0000_801A | 32'((n / 3 - 1) << 5));
      for (int i = 0; i < n; i++) begin
         w = {aa, tbl[i % 12][27:0]};
         s += bsum(w);
         wr(8'h04, w);
         if (i == 1) wr(8'h04, fw);
      end
      wr(8'h04, {aa, 12'h000, s + skew});
      c = 0;
      while (ufa !== 1'b1 && c < 40) begin
         @(posedge hclk);
         c++;
      end
      if (c >= 40) begin
         error_cnt++;
         wrap_up();
      end
      // half a period per unused slot, a few cycles of register delay
      f = (48 - n) / 2;
      chk(32'(c >= f && c <= f + 3), 32'h1);
      xfer(1'b0, 8'h14, 32'h0000_0000, r);
      chk(r, 32'(s));
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(32'({flen, dec, f3, dok}), 32'h0000_000A);
      coef(0, 27'h000_0000);
      xfer(1'b0, 8'h20, 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      dl(4'b0000, 12, 32'h1055_0055, 16'h0000);
      chk(32'(dok), 32'h1);
      chk(32'(flen), 32'h3);
      coef(0, 27'h32B_9688);
      coef(11, 27'h404_3B5F);
      coef(12, 27'h000_0000);
      // download mode must be over: this word is not a coefficient
      wr(8'h04, 32'h0000_0777);
      coef(0, 27'h32B_9688);
      wr(8'h00, 32'h0000_027A);
      repeat (3) @(posedge hclk);
      chk(32'(syncs), 32'h1);
      wr(8'h00, 32'h0000_087A);
      wr(8'h08, 32'h0000_0000);
      xfer(1'b0, 8'h10, 32'h0000_0000, r);
      chk(r & 32'h0000_009F, 32'h0000_009A);
      xfer(1'b0, 8'h0C, 32'h0000_0000, r);
      chk(r, 32'h0000_0088);
      chk(32'(hresp), 32'h0);
      // a non-status selection answers once, then data reads resume
      wr(8'h00, 32'h0000_407A);
      wr(8'h08, 32'h0000_0000);
      xfer(1'b0, 8'h10, 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      wr(8'h08, 32'h0000_0000);
      xfer(1'b0, 8'h10, 32'h0000_0000, r);
      chk(r, 32'h0000_00FA);
      strap <= 3'b101;
      dl(4'b1000, 6, 32'h9000_0000, 16'h0001);
      chk(32'(dok), 32'h0);
      chk(32'(flen), 32'h1);
      coef(6, 27'h000_0000);
      dl(4'b0101, 48, 32'h6000_0000, 16'h0000);
      chk(32'(dok), 32'h1);
      coef(47, 27'h404_3B5F);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      coef(47, 27'h000_0000);
      chk(32'(dok), 32'h0);
      wrap_up();
   end
endmodule

// >>> verification/fir_dl_asserts.sv
// concurrent checks on the coefficient download link
`timescale 1ns/1ns
module fir_dl_asserts (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        word_valid,
   input wire logic [31:0] word_data,
   input wire logic        read_req,
   input wire logic        read_valid,
   input wire logic [15:0] read_word
);
   logic        stat_q;
   logic [15:0] ctl_q;
   ////////////////////////////////////////////////////////////////////////
   // last control word; assumes no coefficient word has 0x0001 on top
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= 1'b0;
         ctl_q  <= 16'h001A;
      end else if (word_valid && word_data[31:16] == 16'h0001) begin
         stat_q <= word_data[11];
         ctl_q  <= word_data[15:0];
      end else if (read_valid) begin
         stat_q <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_ask;
      read_req;
   endsequence
   sequence s_give;
      ##1 read_valid;
   endsequence
   a_read_answer: assert property (s_ask |-> s_give)
      else $error("read request got no answer");
   a_read_single: assert property (read_valid |=> !read_valid)
      else $error("read answer longer than one cycle");
   a_read_unasked: assert property (!read_req |=> !read_valid)
      else $error("read answer without request");
   a_read_hold: assert property (
      !read_valid |-> $stable(read_word))
      else $error("read word moved without answer");
   a_req_pulse: assert property (read_req |=> !read_req)
      else $error("read request longer than one cycle");
   a_word_pulse: assert property (word_valid |=> !word_valid)
      else $error("word strobe longer than one cycle");
   a_reset_quiet: assert property ($rose(hresetn) |->
      !word_valid && !read_req && !read_valid)
      else $error("link busy right after reset");
   a_stat_dec: assert property (read_valid && stat_q |->
      read_word[4:0] == ctl_q[4:0])
      else $error("status word settings differ from control");
endmodule
